// >>> sac_conv.sv
// conversion sequencer of a 12-bit successive-approximation converter
`default_nettype none
// Notes on behaviour
// - start falling edge clears the logic and begins a fresh conversion
// - twelve bits resolved one per step, most significant first
// - full conversion within 20 us slow or 8 us fast
// - 10 bits within 15/6 us, 8 bits within 10/4 us
// - parallel result stands until the next start command
// - result is complemented; a separate inverted msb gives two's complement
// - each decision goes out serially, msb first, complemented, nrz
// - end-of-conversion high through clearing and conversion, falls when done
// - clock out is a positive pulse per step
// - short-cycle input tied to next bit output ends the conversion early
`include "sac_cfg.svh"
module sac_conv
    import sac_pkg::*;
#(
    parameter bit FAST_VARIANT = 1'b0
) (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  startConv,
    input  wire logic                  compHigh,
    input  wire logic                  shortCycleN,
    input  wire logic [1:0]            rateSel,
    output logic      [`SAC_RES_W-1:0] parData,
    output logic                       parMsbN,
    output logic                       serData,
    output logic                       eocBusy,
    output logic                       clkOut,
    output logic                       resValid,
    input  wire logic                  resReady,
    output logic      [`SAC_RES_W-1:0] resData
);
    logic [1:0]             rstPipe;
    logic                   rstSyncN;
    logic [`SAC_PIN_W-1:0]  pinMeta;
    logic [`SAC_PIN_W-1:0]  pinSync2;
    logic [`SAC_PIN_W-1:0]  pinSync3;
    logic [`SAC_PIN_W-1:0]  pinStable;
    logic [`SAC_PIN_W-1:0]  next_pinStable;
    logic                   startFall;
    logic                   compBit;
    logic                   shortLow;
    logic [1:0]             rate;
    sac_state_t             state;
    logic [3:0]             bitIdx;
    logic [5:0]             stepCnt;
    logic [5:0]             stepLen;
    logic                   stepEnd;
    logic                   fifoPush;
    logic [9:0]             convCnt;
    logic [3:0]             endIdx;

    // step length in cycles for the chosen rate and variant
    function automatic logic [5:0] stepCycles(input logic [1:0] r, input logic fast);
        case (r)
            2'h1:    return fast ? 6'(`SAC_STEP(`SAC_T10_FAST_NS, `SAC_STEPS10))
                                 : 6'(`SAC_STEP(`SAC_T10_SLOW_NS, `SAC_STEPS10));
            2'h2,
            2'h3:    return fast ? 6'(`SAC_STEP(`SAC_T8_FAST_NS, `SAC_STEPS8))
                                 : 6'(`SAC_STEP(`SAC_T8_SLOW_NS, `SAC_STEPS8));
            default: return fast ? 6'(`SAC_STEP(`SAC_T12_FAST_NS, `SAC_STEPS12))
                                 : 6'(`SAC_STEP(`SAC_T12_SLOW_NS, `SAC_STEPS12));
        endcase
    endfunction

    // longest conversion in cycles for a rate, less the pin latency ahead of us
    function automatic logic [9:0] limitCycles(input logic [1:0] r, input logic fast);
        case (r)
            2'h1:    return fast ? 10'(`SAC_CYC(`SAC_T10_FAST_NS) - 4) : 10'(`SAC_CYC(`SAC_T10_SLOW_NS) - 4);
            2'h2,
            2'h3:    return fast ? 10'(`SAC_CYC(`SAC_T8_FAST_NS) - 4) : 10'(`SAC_CYC(`SAC_T8_SLOW_NS) - 4);
            default: return fast ? 10'(`SAC_CYC(`SAC_T12_FAST_NS) - 4) : 10'(`SAC_CYC(`SAC_T12_SLOW_NS) - 4);
        endcase
    endfunction

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe[1];

    // every pin passes three flops; the first feeds only the second
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pinMeta  <= `SAC_PIN_IDLE;
            pinSync2 <= `SAC_PIN_IDLE;
            pinSync3 <= `SAC_PIN_IDLE;
        end else begin
            pinMeta  <= {rateSel, shortCycleN, compHigh, startConv};
            pinSync2 <= pinMeta;
            pinSync3 <= pinSync2;
        end
    end

    // a pin level counts only once the second and third flops agree
    always_comb begin
        next_pinStable = (pinSync2 & ~(pinSync2 ^ pinSync3)) | (pinStable & (pinSync2 ^ pinSync3));
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pinStable <= `SAC_PIN_IDLE;
        end else begin
            pinStable <= next_pinStable;
        end
    end

    // pulses shorter than two clocks may be missed; the host keeps them long enough
    assign startFall = pinStable[`SAC_PIN_START] & ~next_pinStable[`SAC_PIN_START];
    assign compBit   = pinStable[`SAC_PIN_COMP];
    assign shortLow  = ~pinStable[`SAC_PIN_SHORT];
    assign rate      = pinStable[`SAC_PIN_RATE +: 2];
    assign stepLen   = stepCycles(rate, FAST_VARIANT);
    assign stepEnd   = (stepCnt == 6'h00);

    // internal step clock; free running, restarted by a start edge
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            stepCnt <= 6'h00;
        end else if (startFall || stepEnd) begin
            stepCnt <= stepLen - 6'h01;
        end else begin
            stepCnt <= stepCnt - 6'h01;
        end
    end

    // clock out high for the first half of each step
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            clkOut <= 1'b0;
        end else begin
            clkOut <= (stepCnt >= {1'b0, stepLen[5:1]});
        end
    end

    // sequencer: clearing step, bit trials, hand-off to the result fifo
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state   <= SAC_IDLE;
            bitIdx  <= `SAC_BIT_MSB;
            parData <= `SAC_RES_IDLE;
            parMsbN <= 1'b0;
            serData <= 1'b1;
            eocBusy <= 1'b0;
        end else if (startFall) begin
            // abandon whatever was running
            state   <= SAC_CLEAR;
            bitIdx  <= `SAC_BIT_MSB;
            parData <= `SAC_RES_IDLE;
            parMsbN <= 1'b0;
            eocBusy <= 1'b1;
        end else begin
            unique case (state)
                SAC_IDLE: begin
                    // result lines stay untouched here
                end
                SAC_CLEAR: begin
                    if (stepEnd) begin
                        state               <= SAC_BIT;
                        parData[bitIdx]     <= 1'b0;
                        parMsbN             <= 1'b1;
                    end
                end
                SAC_BIT: begin
                    if (shortLow) begin
                        // pin tied to the bit under trial: drop it and stop
                        state           <= SAC_HOLD;
                        parData[bitIdx] <= 1'b1;
                        if (bitIdx == `SAC_BIT_MSB) begin
                            parMsbN <= 1'b0;
                        end
                    end else if (stepEnd) begin
                        parData[bitIdx] <= ~compBit;
                        serData         <= ~compBit;
                        if (bitIdx == `SAC_BIT_MSB) begin
                            parMsbN <= compBit;
                        end
                        if (bitIdx == 4'h0) begin
                            state <= SAC_HOLD;
                        end else begin
                            bitIdx                 <= bitIdx - 4'h1;
                            parData[bitIdx - 4'h1] <= 1'b0;
                        end
                    end
                end
                SAC_HOLD: begin
                    // result already stands; status falls on the next edge whatever the queue does
                    state   <= SAC_IDLE;
                    eocBusy <= 1'b0;
                end
            endcase
        end
    end

    // the word is offered once; a full queue loses it rather than stretch
    // the conversion past its time limit
    assign fifoPush = (state == SAC_HOLD) & ~startFall;

    sac_fifo #(
        .WIDTH (`SAC_RES_W),
        .DEPTH (`SAC_FIFO_DEPTH),
        .AW    (`SAC_FIFO_AW)
    ) resultFifo (
        .clk      (clk),
        .rstSyncN (rstSyncN),
        .inValid  (fifoPush),
        .inReady  (),
        .inData   (parData),
        .outValid (resValid),
        .outReady (resReady),
        .outData  (resData)
    );

    // helper: cycles since the start edge, and where a conversion ended
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            convCnt <= 10'h000;
            endIdx  <= 4'h0;
        end else begin
            if (startFall) begin
                convCnt <= 10'h001;
            end else if (eocBusy && convCnt != 10'h3ff) begin
                convCnt <= convCnt + 10'h001;
            end
            if (state == SAC_BIT && !startFall && (shortLow || (stepEnd && bitIdx == 4'h0))) begin
                endIdx <= bitIdx;
            end
        end
    end

    AST_START_CLEARS: assert property (@(posedge clk) disable iff (!rstSyncN)
        startFall |=> (state == SAC_CLEAR) && eocBusy && (parData == `SAC_RES_IDLE))
        else $error("start edge did not restart the conversion");

    AST_MSB_FIRST: assert property (@(posedge clk) disable iff (!rstSyncN)
        (state == SAC_CLEAR && stepEnd && !startFall)
        |=> (state == SAC_BIT) && (bitIdx == `SAC_BIT_MSB) && !parData[11])
        else $error("first trial is not the msb");

    AST_BIT_DOWN: assert property (@(posedge clk) disable iff (!rstSyncN)
        (state == SAC_BIT && stepEnd && !shortLow && !startFall && bitIdx != 4'h0)
        |=> (bitIdx == $past(bitIdx) - 4'h1) && (state == SAC_BIT))
        else $error("bit index did not step down by one");

    AST_FULL_TIME: assert property (@(posedge clk) disable iff (!rstSyncN)
        ($fell(eocBusy) && rate == 2'h0) |-> convCnt <= limitCycles(2'h0, FAST_VARIANT))
        else $error("12-bit conversion too slow");

    AST_SHORT_TIME: assert property (@(posedge clk) disable iff (!rstSyncN)
        ($fell(eocBusy) && ((rate == 2'h1 && endIdx == 4'h1) || (rate[1] && endIdx == 4'h3)))
        |-> convCnt <= limitCycles(rate, FAST_VARIANT))
        else $error("short-cycled conversion too slow");

    AST_RESULT_HELD: assert property (@(posedge clk) disable iff (!rstSyncN)
        (state == SAC_IDLE && !startFall) |=> $stable(parData) && $stable(parMsbN))
        else $error("result changed without a start");

    AST_MSB_PAIR: assert property (@(posedge clk) disable iff (!rstSyncN)
        (state != SAC_CLEAR) |-> (parMsbN == ~parData[11]))
        else $error("inverted msb out of step");

    AST_SERIAL_BIT: assert property (@(posedge clk) disable iff (!rstSyncN)
        (state == SAC_BIT && stepEnd && !shortLow && !startFall)
        |=> serData == parData[$past(bitIdx)])
        else $error("serial bit differs from parallel bit");

    AST_EOC_BUSY: assert property (@(posedge clk) disable iff (!rstSyncN)
        (state != SAC_IDLE) |-> eocBusy)
        else $error("status low during conversion");

    AST_CLOCK_OUT: assert property (@(posedge clk) disable iff (!rstSyncN)
        stepEnd |-> ##2 clkOut ##0 !stepEnd)
        else $error("no clock pulse at step start");

    AST_SHORT_STOP: assert property (@(posedge clk) disable iff (!rstSyncN)
        (state == SAC_BIT && shortLow && !startFall)
        |=> (state == SAC_HOLD) && parData[$past(bitIdx)])
        else $error("short cycle did not end the conversion");

    AST_DATA_FIRST: assert property (@(posedge clk) disable iff (!rstSyncN)
        $fell(eocBusy) |-> $stable(parData) && $past(state) == SAC_HOLD)
        else $error("result moved at the status edge");

    AST_EOC_FALL: assert property (@(posedge clk) disable iff (!rstSyncN)
        (state == SAC_HOLD && !startFall) |=> !eocBusy && (state == SAC_IDLE))
        else $error("status did not fall after the last decision");

    AST_ONE_PER_STEP: assert property (@(posedge clk) disable iff (!rstSyncN)
        (state == SAC_BIT && !stepEnd && !shortLow && !startFall) |=> $stable(bitIdx))
        else $error("bit index moved inside a step");
endmodule
`default_nettype wire

// >>> sac_cfg.svh
// timing counts, pin positions and reset values of the conversion sequencer
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// result width and fifo depth
`define SAC_RES_W        12
`define SAC_FIFO_DEPTH   16
`define SAC_FIFO_AW      4

// system clock period in ns (25 MHz)
`define SAC_CLK_NS       40

// longest conversion times in ns, per resolution and variant
`define SAC_T12_SLOW_NS  20000
`define SAC_T12_FAST_NS  8000
`define SAC_T10_SLOW_NS  15000
`define SAC_T10_FAST_NS  6000
`define SAC_T8_SLOW_NS   10000
`define SAC_T8_FAST_NS   4000

// least start pulse width seen on the pin, ns
`define SAC_START_MIN_NS 100

// cycles lost to the pin synchronisers and the final hand-off
`define SAC_MARGIN       8

// steps per conversion: one clearing step plus one per bit
`define SAC_STEPS12      13
`define SAC_STEPS10      11
`define SAC_STEPS8       9

// longest times as whole cycles, rounded down
`define SAC_CYC(ns)      ((ns) / `SAC_CLK_NS)
// step length in cycles so that the whole conversion meets its limit
`define SAC_STEP(ns, n)  ((`SAC_CYC(ns) - `SAC_MARGIN) / (n))

// pin positions inside the synchroniser vector
`define SAC_PIN_START    0
`define SAC_PIN_COMP     1
`define SAC_PIN_SHORT    2
`define SAC_PIN_RATE     3
`define SAC_PIN_W        5

// reset values
`define SAC_PIN_IDLE     5'h04
`define SAC_RES_IDLE     12'hfff
`define SAC_BIT_MSB      4'hb

`endif

// >>> sac_pkg.sv
// types shared by the conversion sequencer files
`default_nettype none
`include "sac_cfg.svh"
package sac_pkg;

    // conversion phases, one-hot
    typedef enum logic [3:0] {
        SAC_IDLE  = 4'h1,
        SAC_CLEAR = 4'h2,
        SAC_BIT   = 4'h4,
        SAC_HOLD  = 4'h8
    } sac_state_t;

    typedef logic [`SAC_RES_W-1:0] sac_word_t;

endpackage
`default_nettype wire

// >>> sac_fifo.sv
// result fifo with a registered output stage
`default_nettype none
module sac_fifo
    import sac_pkg::*;
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clk,
    input  wire logic             rstSyncN,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic             doPush;
    logic             doPop;

    // full when every entry is taken; output register is extra room
    assign inReady = (count != (AW+1)'(DEPTH));
    assign doPush  = inValid & inReady;
    assign doPop   = (count != '0) & (~outValid | outReady);

    // storage needs no reset
    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[wrPtr] <= inData;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doPop) begin
                rdPtr <= rdPtr + 1'b1;
            end
            count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end

    // read data leave through a register
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            outValid <= 1'b0;
            outData  <= '0;
        end else if (doPop) begin
            outValid <= 1'b1;
            outData  <= mem[rdPtr];
        end else if (outReady) begin
            outValid <= 1'b0;
        end
    end

    AST_FIFO_LEVEL: assert property (@(posedge clk) disable iff (!rstSyncN)
        count <= (AW+1)'(DEPTH))
        else $error("fifo level above depth");
endmodule
`default_nettype wire

// >>> sac_host_model.sv
// host side model: start pulses, comparator input and result consumer
`default_nettype none
module sac_host_model
    import sac_pkg::*;
#(
    parameter int START_HIGH_CYC = 4,
    parameter int SETTLE_NS      = 3000
) (
    input  wire logic      clk,
    input  wire sac_word_t parData,
    output logic           startConv,
    output logic           compHigh,
    input  wire logic      resValid,
    output logic           resReady,
    input  wire sac_word_t resData
);
    timeunit 1ns;
    timeprecision 1ps;

    sac_word_t vin;
    bit        bufferUsed;
    int        stall;

    initial begin
        vin = 12'h000;
        bufferUsed = 1'b0;
        stall = 0;
        startConv = 1'b0;
        compHigh = 1'b0;
        resReady = 1'b0;
    end

    // comparator: trial level is the complement of the pattern on the lines
    always @(negedge clk) begin
        compHigh <= (vin >= ~parData);
    end

    // one start command; the falling edge is the conversion command
    // one start edge per conversion: the start pin is never run as a clock
    task automatic pulse_start();
        if (bufferUsed)
            #(SETTLE_NS);
        @(negedge clk);
        startConv = 1'b1;
        repeat (START_HIGH_CYC) @(negedge clk);
        startConv = 1'b0;
    endtask

    // take one word; ready only rises once valid is seen, a slow sink
    task automatic pop(output sac_word_t w);
        int n;
        w = 'x;
        repeat (stall) @(negedge clk);
        for (n = 0; n < 2000; n++) begin
            @(negedge clk);
            if (resValid === 1'b1)
                break;
        end
        if (resValid === 1'b1) begin
            w = resData;
            resReady = 1'b1;
            @(negedge clk);
            resReady = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// >>> tb_sac_conv.sv
// self-checking testbench of the conversion sequencer
`default_nettype none
`include "sac_cfg.svh"
module tb_sac_conv
    import sac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic      clk, rstn, startConv, compHigh, shortCycleN;
    logic      parMsbN, serData, eocBusy, clkOut, resValid, resReady;
    logic [1:0] rateSel;
    sac_word_t parData, resData;
    int        n_fail = 0;
    int        num_checks = 0;
    int        curMode = 0;

    // per mode: full, 10-bit and 8-bit short cycle at both 8-bit rate codes
    localparam logic [1:0] RATE [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    localparam int         TIE  [4] = '{0, 1, 3, 3};
    localparam sac_word_t  MASK [4] = '{12'h000, 12'h003, 12'h00f, 12'h00f};
    localparam int LIMIT [4] = '{`SAC_CYC(`SAC_T12_SLOW_NS), `SAC_CYC(`SAC_T10_SLOW_NS), `SAC_CYC(`SAC_T8_SLOW_NS),
                                 `SAC_CYC(`SAC_T8_SLOW_NS)};

    sac_conv #(.FAST_VARIANT(1'b0)) uut (
        .clk(clk), .rstn(rstn), .startConv(startConv), .compHigh(compHigh),
        .shortCycleN(shortCycleN), .rateSel(rateSel), .parData(parData), .parMsbN(parMsbN),
        .serData(serData), .eocBusy(eocBusy), .clkOut(clkOut), .resValid(resValid),
        .resReady(resReady), .resData(resData)
    );

    sac_host_model host (
        .clk(clk), .parData(parData), .startConv(startConv), .compHigh(compHigh),
        .resValid(resValid), .resReady(resReady), .resData(resData)
    );

    always #20 clk = ~clk;

    // short-cycle pin tied to the line after the last wanted bit
    always @(negedge clk) begin
        shortCycleN <= (curMode == 0) ? 1'b1 : parData[TIE[curMode]];
    end

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one conversion of v; blocked means the result queue is already full
    task automatic convert(input sac_word_t v, input int mode, input bit blocked, input bit take);
        sac_word_t exp, sbits, w;
        int        n, k;
        logic      prevClk;
        exp = ~v | MASK[mode];
        curMode = mode;
        rateSel = RATE[mode];
        host.vin = v;
        host.pulse_start();
        n = 0;
        k = 0;
        prevClk = 1'b0;
        sbits = 12'hfff;
        // clearing pulse skipped: it may merge with a free-running pulse before the start
        while (n < LIMIT[mode] + 20) begin
            @(negedge clk);
            n++;
            if (n >= 8 && eocBusy === 1'b1 && clkOut === 1'b1 && prevClk !== 1'b1) begin
                k++;
                if (k >= 2 && k <= 12)
                    sbits[13-k] = serData; // decision of the previous step
            end
            prevClk = clkOut;
            if (n >= 8 && eocBusy !== 1'b1)
                break;
        end
        if (blocked) begin
            check("status falls with queue full", {11'h000, eocBusy}, 12'h000);
        end
        check("within time limit", {11'h000, n <= LIMIT[mode]}, 12'h001);
        check("parallel result", parData, exp);
        check("inverted msb", {11'h000, parMsbN}, {11'h000, ~exp[11]});
        if (mode == 0) begin
            sbits[0] = serData;
            check("serial stream", sbits, exp);
            check("clock pulses", k[11:0], 12'h00c);
        end
        repeat (40) @(negedge clk);
        check("result held", parData, exp);
        check("status after end", {11'h000, eocBusy}, 12'h000);
        if (take) begin
            host.pop(w);
            check("queued word", w, exp);
        end
    endtask

    task automatic test_reset();
        check("reset outputs", {7'h00, parMsbN, serData, eocBusy, clkOut, resValid}, 12'h008);
        check("reset result", parData, 12'hfff);
        $display("test reset done");
    endtask

    task automatic test_modes();
        sac_word_t vals [3] = '{12'ha5c, 12'h3c9, 12'hfff};
        for (int m = 0; m < 4; m++) begin
            for (int i = 0; i < 3; i++) begin
                host.bufferUsed = (i == 1);
                convert(vals[i] ^ sac_word_t'(m), m, 1'b0, 1'b1);
            end
        end
        host.bufferUsed = 1'b0;
        $display("test modes done");
    endtask

    task automatic test_restart();
        curMode = 0;
        rateSel = 2'h0;
        host.vin = 12'h123;
        host.pulse_start();
        repeat (100) @(negedge clk);
        check("busy mid conversion", {11'h000, eocBusy}, 12'h001);
        convert(12'h6e1, 0, 1'b0, 1'b1);
        repeat (5) @(negedge clk);
        check("abandoned word absent", {11'h000, resValid}, 12'h000);
        $display("test restart done");
    endtask

    task automatic test_fifo();
        sac_word_t w;
        for (int i = 0; i < 17; i++)
            convert(sac_word_t'(i * 183 + 5), 0, 1'b0, 1'b0);
        convert(12'h0c3, 0, 1'b1, 1'b0);
        host.stall = 7;
        // the word finished while the queue was full is lost, so 17 come back
        for (int i = 0; i < 17; i++) begin
            host.pop(w);
            check("drained word", w, ~sac_word_t'(i * 183 + 5));
        end
        host.stall = 0;
        repeat (5) @(negedge clk);
        check("queue empty", {11'h000, resValid}, 12'h000);
        $display("test fifo done");
    endtask

    // watchdog sized well above the longest expected run
    initial begin
        #(60000 * `SAC_CLK_NS);
        n_fail++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        rateSel = 2'h0;
        shortCycleN = 1'b1;
        repeat (4) @(negedge clk);
        test_reset();
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        test_modes();
        test_restart();
        test_fifo();
        report_and_stop();
    end
endmodule
`default_nettype wire
